// *** common/slow_pulse_pkg.sv ***
// Shared constants and types for the slow pulse timing generator
package slow_pulse_pkg;

    // Widths and counts
    localparam int PHASE_CNT   = 4;
    localparam int SYNC_STAGES = 2;
    localparam int SYNC_WIDTH  = 7;

    // Positions in the synchroniser bank (phase 1 sits at bit 0)
    localparam int IDX_PH2   = 1;
    localparam int IDX_PH3   = 2;
    localparam int IDX_PH4   = 3;
    localparam int IDX_LATE4 = 4;
    localparam int IDX_REF   = 5;
    localparam int IDX_PASS  = 6;

    // Values after reset
    localparam logic                  RST_FLOP  = 1'b0;
    localparam logic [PHASE_CNT-1:0]  RST_PHASE = 4'h0;
    localparam logic [SYNC_WIDTH-1:0] RST_SYNC  = 7'h00;

    // Reference pulses per slow pulse, as the last count of a 0..3 counter
    localparam logic [1:0] REF_LAST = 2'h3;
    localparam logic [1:0] REF_ZERO = 2'h0;
    localparam logic [1:0] REF_ONE  = 2'h1;

    // Slow sequence states, one-hot
    typedef enum logic [3:0] {
        SEQ_IDLE = 4'b0001,
        SEQ_P2   = 4'b0010,
        SEQ_P3   = 4'b0100,
        SEQ_P4   = 4'b1000
    } seq_state_e;

endpackage

// *** design/slow_pulse_timing_generator.sv ***
// Drum phase pulse distributor and 91 pps slow pulse generator
//
// Contract
// - Four phase gate paths, all opened together by the timing pass level.
// - Each gated phase pulse drives storage, drum, computer and test consumers.
// - Two divider stages, flop plus gate each, take 364 pps to 91 pps.
// - First stage emits 182 pps, sole input of the second stage.
// - Reference toggles flop A; passes gate A only if A already set.
// - Gate A pulse toggles flop B; gate B passes when both set.
// - Fourth reference pulse clears both flops; one output per four inputs.
// - 91 pps pulses reach the synchroniser only while pass level is high.
// - Admitted pulse arms; armed sync gate passes next late phase-4 pulse.
// - Phase-2 slow pulse disarms before the next late phase-4 pulse.
// - Sync pulse starts one phase-2, phase-3, phase-4 slow sequence, then stops.
`timescale 1ns/100ps
`default_nettype none
module slow_pulse_timing_generator
    import slow_pulse_pkg::*;
#(
    parameter int PHASES = PHASE_CNT
) (
    // Clock and synchronous reset
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    // Drum timing source and test equipment
    input  wire logic [PHASES-1:0] drum_phase_pulse_i,
    input  wire logic              late_phase4_pulse_i,
    input  wire logic              ref_pulse_i,
    input  wire logic              timing_pass_level_i,
    // Gated phase pulses to the four consumers
    output logic      [PHASES-1:0] store_phase_o,
    output logic      [PHASES-1:0] drum_phase_o,
    output logic      [PHASES-1:0] comp_phase_o,
    output logic      [PHASES-1:0] test_phase_o,
    // Divider outputs
    output logic                   div182_pulse_o,
    output logic                   div91_pulse_o,
    // Synchronised slow pulses
    output logic                   slow_sync_pulse_o,
    output logic                   phase2_slow_pulse_o,
    output logic                   phase3_slow_pulse_o,
    output logic                   phase4_slow_pulse_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [SYNC_WIDTH-1:0] pin_raw;
    logic [SYNC_WIDTH-1:0] pin_sync;
    logic [SYNC_WIDTH-1:0] pin_prev_ff;
    logic [SYNC_WIDTH-1:0] nxt_pin_prev;

    // Every input crosses in from the drum timing source or the test equipment
    assign pin_raw = {timing_pass_level_i, ref_pulse_i, late_phase4_pulse_i,
                      drum_phase_pulse_i};

    sync_bank #(
        .WIDTH (SYNC_WIDTH)
    ) u_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .async_i (pin_raw),
        .sync_o  (pin_sync)
    );

    // Previous synced value, for rising edge detection
    always_comb begin
        nxt_pin_prev = pin_sync;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            pin_prev_ff <= RST_SYNC;
        end else begin
            pin_prev_ff <= nxt_pin_prev;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event decode

    logic              pass_lvl;
    logic [PHASES-1:0] phase_gated;
    logic [PHASES-1:0] phase_gated_prev;
    logic [PHASES-1:0] phase_evt;
    logic              late4_evt;
    logic              ref_evt;

    // Wide pulses count once: only rising edges drive the slow logic
    assign pass_lvl         = pin_sync[IDX_PASS];
    assign phase_gated      = pin_sync[PHASES-1:0] & {PHASES{pass_lvl}};
    assign phase_gated_prev = pin_prev_ff[PHASES-1:0] & {PHASES{pass_lvl}};
    assign phase_evt        = phase_gated & ~phase_gated_prev;
    assign late4_evt        = pass_lvl & pin_sync[IDX_LATE4] & ~pin_prev_ff[IDX_LATE4];
    assign ref_evt          = pin_sync[IDX_REF] & ~pin_prev_ff[IDX_REF];

    ////////////////////////////////////////////////////////////////////////
    // Phase pulse fan-out

    logic [PHASES-1:0] fan_ff      [PHASES];
    logic [PHASES-1:0] nxt_fan     [PHASES];

    // One register per consumer so each output comes from its own flop
    genvar gi;
    generate
        for (gi = 0; gi < PHASES; gi++) begin : g_fan
            always_comb begin
                nxt_fan[gi] = phase_gated;
            end

            always_ff @(posedge mclk_i) begin
                if (srst_i) begin
                    fan_ff[gi] <= RST_PHASE;
                end else begin
                    fan_ff[gi] <= nxt_fan[gi];
                end
            end
        end
    endgenerate

    assign store_phase_o = fan_ff[0];
    assign drum_phase_o  = fan_ff[1];
    assign comp_phase_o  = fan_ff[2];
    assign test_phase_o  = fan_ff[3];

    ////////////////////////////////////////////////////////////////////////
    // Divide by four

    logic divider_a_flop_ff;
    logic divider_b_flop_ff;
    logic div182_ff;
    logic div91_ff;
    logic nxt_divider_a_flop;
    logic nxt_divider_b_flop;
    logic nxt_div182;
    logic nxt_div91;
    logic divider_a_gate;
    logic divider_b_gate;

    // Gates look at the flops before the pulse toggles them
    assign divider_a_gate = ref_evt & divider_a_flop_ff;
    assign divider_b_gate = divider_a_gate & divider_b_flop_ff;

    always_comb begin
        nxt_divider_a_flop = divider_a_flop_ff ^ ref_evt;
        nxt_divider_b_flop = divider_b_flop_ff ^ divider_a_gate;
        nxt_div182         = divider_a_gate;
        nxt_div91          = divider_b_gate;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            divider_a_flop_ff <= RST_FLOP;
            divider_b_flop_ff <= RST_FLOP;
            div182_ff         <= RST_FLOP;
            div91_ff          <= RST_FLOP;
        end else begin
            divider_a_flop_ff <= nxt_divider_a_flop;
            divider_b_flop_ff <= nxt_divider_b_flop;
            div182_ff         <= nxt_div182;
            div91_ff          <= nxt_div91;
        end
    end

    assign div182_pulse_o = div182_ff;
    assign div91_pulse_o  = div91_ff;

    ////////////////////////////////////////////////////////////////////////
    // Arm flop and sync gate

    logic slow_arm_flop_ff;
    logic sync_ff;
    logic nxt_slow_arm_flop;
    logic nxt_sync;
    logic slow_admit_gate;
    logic slow_sync_gate;
    logic p2_slow_evt;

    // Unit loop tests drop the pass level and starve the synchroniser
    assign slow_admit_gate = divider_b_gate & pass_lvl;
    assign slow_sync_gate  = slow_arm_flop_ff & late4_evt;

    // A fresh admit wins over the phase-2 clear in the same cycle
    always_comb begin
        nxt_slow_arm_flop = slow_admit_gate | (slow_arm_flop_ff & ~p2_slow_evt);
        nxt_sync          = slow_sync_gate;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            slow_arm_flop_ff <= RST_FLOP;
            sync_ff          <= RST_FLOP;
        end else begin
            slow_arm_flop_ff <= nxt_slow_arm_flop;
            sync_ff          <= nxt_sync;
        end
    end

    assign slow_sync_pulse_o = sync_ff;

    ////////////////////////////////////////////////////////////////////////
    // Pulse-stop sequence

    seq_state_e seq_ff;
    seq_state_e nxt_seq;
    logic       p2_ff;
    logic       p3_ff;
    logic       p4_ff;
    logic       nxt_p2;
    logic       nxt_p3;
    logic       nxt_p4;
    logic       pulse_stop_flop;

    // Any state but idle stands for the pulse-stop flop being set
    assign pulse_stop_flop = (seq_ff != SEQ_IDLE);
    assign p2_slow_evt     = (seq_ff == SEQ_P2) & phase_evt[IDX_PH2];

    always_comb begin
        nxt_seq = seq_ff;
        nxt_p2  = 1'b0;
        nxt_p3  = 1'b0;
        nxt_p4  = 1'b0;
        case (seq_ff)
            SEQ_IDLE: begin
                if (slow_sync_gate) begin
                    nxt_seq = SEQ_P2;
                end
            end
            SEQ_P2: begin
                if (phase_evt[IDX_PH2]) begin
                    nxt_p2  = 1'b1;
                    nxt_seq = SEQ_P3;
                end
            end
            SEQ_P3: begin
                if (phase_evt[IDX_PH3]) begin
                    nxt_p3  = 1'b1;
                    nxt_seq = SEQ_P4;
                end
            end
            SEQ_P4: begin
                if (phase_evt[IDX_PH4]) begin
                    nxt_p4  = 1'b1;
                    nxt_seq = SEQ_IDLE;
                end
            end
            default: begin
                nxt_seq = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            seq_ff <= SEQ_IDLE;
            p2_ff  <= RST_FLOP;
            p3_ff  <= RST_FLOP;
            p4_ff  <= RST_FLOP;
        end else begin
            seq_ff <= nxt_seq;
            p2_ff  <= nxt_p2;
            p3_ff  <= nxt_p3;
            p4_ff  <= nxt_p4;
        end
    end

    assign phase2_slow_pulse_o = p2_ff;
    assign phase3_slow_pulse_o = p3_ff;
    assign phase4_slow_pulse_o = p4_ff;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    logic [1:0] ref_cnt_ff;

    // Helper: reference pulses modulo four, for the ratio check
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ref_cnt_ff <= REF_ZERO;
        end else if (ref_evt) begin
            ref_cnt_ff <= ref_cnt_ff + REF_ONE;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);

    fan_all_equal_a: assert property (
        (drum_phase_o == store_phase_o) && (comp_phase_o == store_phase_o)
        && (test_phase_o == store_phase_o)
        && (store_phase_o == ($past(pin_sync[PHASES-1:0]) & {PHASES{$past(pass_lvl)}})))
        else $error("phase fan-out copies differ");

    pass_blocks_phase_a: assert property (
        !pass_lvl |=> (store_phase_o == RST_PHASE))
        else $error("phase pulse passed while pass level low");

    div_a_toggle_a: assert property (
        ref_evt |=> (divider_a_flop_ff != $past(divider_a_flop_ff)))
        else $error("divider A flop did not toggle");

    div182_gate_a: assert property (
        (ref_evt && divider_a_flop_ff) |=> div182_pulse_o)
        else $error("first stage pulse missing");

    div_b_toggle_a: assert property (
        (ref_evt && !divider_a_flop_ff) |=> $stable(divider_b_flop_ff))
        else $error("divider B moved without stage A pulse");

    div91_ratio_a: assert property (
        ref_evt |=> (div91_pulse_o == ($past(ref_cnt_ff) == REF_LAST)))
        else $error("slow pulse not on every fourth reference");

    div_state_sync_a: assert property (
        ref_cnt_ff == {divider_b_flop_ff, divider_a_flop_ff})
        else $error("divider flops out of step with count");

    arm_needs_admit_a: assert property (
        $rose(slow_arm_flop_ff) |-> $past(divider_b_gate && pass_lvl))
        else $error("arm flop set without admitted pulse");

    sync_needs_arm_a: assert property (
        slow_sync_pulse_o |-> ($past(slow_arm_flop_ff) && $past(late4_evt)))
        else $error("sync pulse without arm and late phase 4");

    arm_cleared_a: assert property (
        (phase2_slow_pulse_o && !$past(slow_admit_gate)) |-> !slow_arm_flop_ff)
        else $error("arm flop still set after phase 2 slow pulse");

    stop_released_a: assert property (
        phase4_slow_pulse_o |-> !pulse_stop_flop)
        else $error("pulse stop still set after phase 4 slow pulse");

    reset_clears_div_a: assert property (
        disable iff (1'b0) srst_i |=> (!divider_a_flop_ff && !divider_b_flop_ff))
        else $error("dividers not clear after reset");

endmodule
`default_nettype wire

// *** design/sync_bank.sv ***
// Two-flop synchroniser bank for asynchronous pin inputs
`timescale 1ns/100ps
`default_nettype none
module sync_bank
    import slow_pulse_pkg::*;
#(
    parameter int WIDTH = SYNC_WIDTH
) (
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             srst_i,
    // Raw and synchronised levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    // First stage feeds only the second stage
    always_comb begin
        nxt_meta = async_i;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign sync_o = sync_ff;

endmodule
`default_nettype wire

// *** verif/drum_timing_model.sv ***
// Partner model of the drum timing source feeding the distributor
`timescale 1ns/100ps
`default_nettype none
module drum_timing_model (
    // Clock
    input  wire logic       mclk_i,
    // Pulses toward the generator
    output logic      [3:0] drum_phase_pulse_o,
    output logic            late_phase4_pulse_o
);
    //////////////////////////////////////////////////////////////////////////////
    logic [3:0] slot_ff;

    // Known levels at time zero, before the first edge
    initial begin
        slot_ff             = 4'h0;
        drum_phase_pulse_o  = 4'h0;
        late_phase4_pulse_o = 1'b0;
    end

    // Ten-slot rotation: odd slots are gaps so every pulse is a clean single-cycle edge
    always @(posedge mclk_i) begin
        slot_ff <= (slot_ff == 4'h9) ? 4'h0 : slot_ff + 4'h1;
        // Phases 1..4 in order, one per even slot below 8
        drum_phase_pulse_o <= (!slot_ff[0] && slot_ff < 4'h8) ? (4'h1 << slot_ff[2:1]) : 4'h0;
        // Late phase-4 follows phase 4; phase 2 comes before the next one
        late_phase4_pulse_o <= (slot_ff == 4'h8);
    end
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking testbench for the slow pulse timing generator
`timescale 1ns/100ps
`default_nettype none
module tb_top
    import slow_pulse_pkg::*;
;
    //////////////////////////////////////////////////////////////////////////////
    logic                 mclk_i;
    logic                 srst_i;
    logic                 ref_w;
    logic                 pass_w;
    logic [PHASE_CNT-1:0] phase_w;
    logic                 late_w;
    logic [PHASE_CNT-1:0] store_w, drum_w, comp_w, test_w;
    logic                 d182_w, d91_w, sync_w, p2_w, p3_w, p4_w;
    int                   error_cnt;
    int                   total_checks;

    always #12.5 mclk_i = ~mclk_i;

    drum_timing_model i_drum (
        .mclk_i              (mclk_i),
        .drum_phase_pulse_o  (phase_w),
        .late_phase4_pulse_o (late_w)
    );

    slow_pulse_timing_generator #(.PHASES(PHASE_CNT)) i_dut (
        .mclk_i              (mclk_i),
        .srst_i              (srst_i),
        .drum_phase_pulse_i  (phase_w),
        .late_phase4_pulse_i (late_w),
        .ref_pulse_i         (ref_w),
        .timing_pass_level_i (pass_w),
        .store_phase_o       (store_w),
        .drum_phase_o        (drum_w),
        .comp_phase_o        (comp_w),
        .test_phase_o        (test_w),
        .div182_pulse_o      (d182_w),
        .div91_pulse_o       (d91_w),
        .slow_sync_pulse_o   (sync_w),
        .phase2_slow_pulse_o (p2_w),
        .phase3_slow_pulse_o (p3_w),
        .phase4_slow_pulse_o (p4_w)
    );

    //////////////////////////////////////////////////////////////////////////////
    // Reference model: input history as seen by the two-flop synchronisers
    logic [3:0] h_ph [4];
    logic [3:0] h_late, h_ref, h_pass, p_ev;
    logic [3:0] exp_ph;
    logic       e182, e91, e_sync, e2, e3, e4, late_ev;
    bit         div_a, div_b, arm, started;
    int         seq;

    always @(posedge mclk_i) begin
        for (int i = 3; i > 0; i--) begin
            h_ph[i] = h_ph[i-1];
        end
        // Synchroniser flops clear in reset, so reset edges count as zero
        h_ph[0] = srst_i ? 4'h0 : phase_w;
        h_late  = {h_late[2:0], late_w & ~srst_i};
        h_ref   = {h_ref[2:0], ref_w & ~srst_i};
        h_pass  = {h_pass[2:0], pass_w & ~srst_i};
        {e182, e91, e_sync, e2, e3, e4} = 6'h00;
        exp_ph = 4'h0;
        if (srst_i) begin
            // Everything clears on reset, dividers included
            {div_a, div_b, arm} = 3'b000;
            seq     = 0;
            started = 1'b1;
        end else begin
            exp_ph = h_ph[2] & {4{h_pass[2]}};
            if (h_ref[2] && !h_ref[3]) begin
                if (div_a) begin
                    e182  = 1'b1;
                    e91   = div_b;
                    div_b = !div_b;
                end
                div_a = !div_a;
            end
            late_ev = (h_late[2] & h_pass[2]) && !(h_late[3] & h_pass[3]);
            p_ev    = exp_ph & ~(h_ph[3] & {4{h_pass[3]}});
            e_sync  = arm && late_ev;
            e2      = seq == 1 && p_ev[1];
            e3      = seq == 2 && p_ev[2];
            e4      = seq == 3 && p_ev[3];
            if (e_sync && seq == 0) seq = 1;
            else if (e2) seq = 2;
            else if (e3) seq = 3;
            else if (e4) seq = 0;
            // Admit wins over a same-cycle phase-2 clear
            if (e2) arm = 1'b0;
            if (e91 && h_pass[2]) arm = 1'b1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Compare on the falling edge, well clear of the launching edge
    always @(negedge mclk_i) begin
        if (started) begin
            check(store_w, exp_ph);
            check(drum_w, exp_ph);
            check(comp_w, exp_ph);
            check(test_w, exp_ph);
            check({3'h0, d182_w}, {3'h0, e182});
            check({3'h0, d91_w}, {3'h0, e91});
            check({3'h0, sync_w}, {3'h0, e_sync});
            check({3'h0, p2_w}, {3'h0, e2});
            check({3'h0, p3_w}, {3'h0, e3});
            check({3'h0, p4_w}, {3'h0, e4});
        end
    end

    task automatic results();
        $display("errors %0d checks %0d", error_cnt, total_checks);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle reference strobe followed by a low gap of at least one cycle
    task automatic send_ref(input int gap);
        @(posedge mclk_i) ref_w <= 1'b1;
        @(posedge mclk_i) ref_w <= 1'b0;
        repeat (gap) @(posedge mclk_i);
    endtask

    task automatic burst(input int n, input int max_gap);
        for (int i = 0; i < n; i++) begin
            send_ref($urandom_range(max_gap, 1));
        end
    endtask

    // Pass level only moves after a quiet spell, so no slow sequence is left half done
    task automatic set_pass(input logic lvl);
        repeat (30) @(posedge mclk_i);
        @(posedge mclk_i) pass_w <= lvl;
        repeat (30) @(posedge mclk_i);
    endtask

    //////////////////////////////////////////////////////////////////////////////
    // Watchdog: runs well past the few thousand cycles the sequence needs
    initial begin
        repeat (20000) @(posedge mclk_i);
        error_cnt++;
        results();
    end

    // Main sequence
    initial begin
        mclk_i       = 1'b0;
        srst_i       = 1'b1;
        ref_w        = 1'b0;
        pass_w       = 1'b1;
        error_cnt    = 0;
        total_checks = 0;
        started      = 1'b0;
        h_late       = 4'h0;
        h_ref        = 4'h0;
        h_pass       = 4'h0;
        for (int i = 0; i < 4; i++) begin
            h_ph[i] = 4'h0;
        end
        void'($urandom(32'h2225));
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        // Normal running, random spacing
        burst(40, 40);
        // Unit loop test: pass level low blocks phases and slow pulses
        set_pass(1'b0);
        burst(12, 20);
        set_pass(1'b1);
        // Closest legal spacing of reference strobes
        burst(16, 1);
        // Reset in mid-count, then the count starts over
        send_ref(2);
        @(posedge mclk_i) srst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        srst_i <= 1'b0;
        burst(16, 30);
        repeat (40) @(posedge mclk_i);
        results();
    end
endmodule
`default_nettype wire
